/* srs_params.svh */
// Constants of the reset supervisor: offsets, fields, reset values, times.
// Assumes a 25 MHz reference clock that is also the peripheral bus clock.
`ifndef SRS_PARAMS_SVH
`define SRS_PARAMS_SVH
`define SRS_CLK_NS        40
`define SRS_T_POR_NS      20000
`define SRS_MIN_RESET_PULSE_TIME_NS   1000
`define SRS_POR_CYC       ((`SRS_T_POR_NS + `SRS_CLK_NS - 1) / `SRS_CLK_NS)
`define SRS_RIN_CYC       ((`SRS_MIN_RESET_PULSE_TIME_NS + `SRS_CLK_NS - 1) / `SRS_CLK_NS)
`define SRS_OFF_CTRL      8'h00
`define SRS_OFF_STATUS    8'h04
`define SRS_OFF_WDT_CTRL  8'h08
`define SRS_OFF_WDT_LOAD  8'h0C
`define SRS_OFF_WDT_KICK  8'h10
`define SRS_OFF_WDT_CNT   8'h14
`define SRS_OFF_CLK_CFG   8'h18
`define SRS_OFF_TMP_CTRL  8'h1C
`define SRS_OFF_TMP_TIME  8'h20
`define SRS_OFF_TMP_DATE  8'h24
`define SRS_CTRL_MON_DIS  0
`define SRS_CTRL_IO_BLK   1
`define SRS_CTRL_MSK_CORE 2
`define SRS_CTRL_MSK_IO   3
`define SRS_ST_POWER_UP   0
`define SRS_ST_SUPPLY     1
`define SRS_ST_WATCHDOG   2
`define SRS_ST_PIN        3
`define SRS_ST_DEBUG      4
`define SRS_WDT_EN        0
`define SRS_WDT_WD_MODE   1
`define SRS_TMP_EN        0
`define SRS_TMP_EDGE      1
`define SRS_TMP_RISE      2
`define SRS_TMP_FLAG      8
`define SRS_STATUS_RST    5'h01
`define SRS_WDT_LOAD_RST  16'hFFFF
`define SRS_CLK_CFG_RST   32'h0000_0000
`define SRS_BOOT_VECTOR   32'h0000_0000
`endif

/* srs_partner.sv */
// Board-side model: supply monitors, external reset pin, debug controller.
// Assumes the bench calls its tasks; the reset pin has a pull-up.
`default_nettype none
module srs_partner (
  input  wire logic i_ref_clk,
  output logic      o_power_up,
  output logic      o_core_drop,
  output logic      o_io_low,
  output logic      o_io_high,
  output logic      o_io_nv,
  output logic      o_core_sag,
  output logic      o_io_sag,
  output logic      o_pin_n,
  output logic      o_dbg_mode,
  output logic      o_dbg_cmd
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {o_core_drop, o_io_low, o_io_high, o_io_nv, o_core_sag, o_io_sag} = '0;
    {o_dbg_mode, o_dbg_cmd} = 2'h0;
    o_power_up = 1'b1;
    o_pin_n = 1'b1;
  end
  // Order: power up, core drop, io low, io high, nv, core sag, io sag
  task automatic supply(input logic [6:0] v);
    @(posedge i_ref_clk);
    {o_power_up, o_core_drop, o_io_low, o_io_high, o_io_nv, o_core_sag, o_io_sag} <= v;
  endtask
  // Released pin returns high through the pull-up
  task automatic pin_low(input int n);
    @(posedge i_ref_clk);
    o_pin_n <= 1'b0;
    repeat (n) @(posedge i_ref_clk);
    o_pin_n <= 1'b1;
  endtask
  task automatic dbg_reset();
    @(posedge i_ref_clk);
    {o_dbg_mode, o_dbg_cmd} <= 2'h3;
    @(posedge i_ref_clk);
    {o_dbg_mode, o_dbg_cmd} <= 2'h0;
  endtask
endmodule
`default_nettype wire

/* srs_pkg.sv */
// Types of the reset supervisor.
// Assumes nothing beyond the constants header.
`default_nettype none
package srs_pkg;
  typedef enum logic [1:0] {
    SRS_POR_WAIT = 2'b00,
    SRS_POR_HOLD = 2'b01,
    SRS_RUN      = 2'b11,
    SRS_SYS_HOLD = 2'b10
  } srs_state_e;
endpackage
`default_nettype wire

/* srs_top.sv */
// Reset supervisor: reset sequencing, watchdog, brown-out warning, tamper.
// Assumes APB master on i_ref_clk; supply monitor levels synchronous.
//
// Local design decisions: register access over APB and the register addresses.
`include "srs_params.svh"
`default_nettype none
module srs_top #(
  parameter int POR_CYCLES = `SRS_POR_CYC,
  parameter int RIN_CYCLES = `SRS_RIN_CYC
) (
  input  wire logic               i_ref_clk,
  input  wire logic               i_rst,
  input  wire logic               i_psel,
  input  wire logic               i_penable,
  input  wire logic               i_pwrite,
  input  wire logic [7:0]         i_paddr,
  input  wire logic [31:0]        i_pwdata,
  output logic                    o_pready,
  output logic [31:0]             o_prdata,
  output logic                    o_pslverr,
  input  wire logic               i_power_up,
  input  wire logic               i_core_dropout,
  input  wire logic               i_io_below_low_trip,
  input  wire logic               i_io_below_high_trip,
  input  wire logic               i_io_trip_high_nv,
  input  wire logic               i_core_sag,
  input  wire logic               i_io_sag,
  input  wire logic               i_board_reset_request_pin_n,
  input  wire logic               i_debug_mode,
  input  wire logic               i_debug_reset_cmd,
  input  wire logic               i_tamper_in,
  input  wire logic [31:0]        i_rtc_time,
  input  wire logic [31:0]        i_rtc_date,
  output logic                    o_chip_wide_reset,
  output logic                    o_system_level_reset,
  output logic                    o_board_reset_drive_pin_n,
  output srs_pkg::srs_state_e     o_reset_phase,
  output logic [31:0]             o_fetch_addr,
  output logic [31:0]             o_clock_unit_cfg,
  output logic                    o_brownout_irq,
  output logic                    o_tamper_capture,
  output logic [31:0]             o_tamper_time,
  output logic [31:0]             o_tamper_date,
  output logic                    o_sram_standby_cut
);
  import srs_pkg::*;

  srs_state_e  state_reg;
  srs_state_e  state_next;
  logic [15:0] hold_cnt_reg;
  logic        pin_s1_reg;
  logic        pin_s2_reg;
  logic [15:0] pin_lo_cnt_reg;
  logic        pin_req;
  logic [3:0]  ctrl_reg;
  logic [4:0]  status_reg;
  logic        wdt_en_reg;
  logic        wdt_mode_reg;
  logic [7:0]  wdt_presc_reg;
  logic [7:0]  presc_cnt_reg;
  logic [15:0] wdt_load_reg;
  logic [15:0] wdt_cnt_reg;
  logic [2:0]  tmp_ctrl_reg;
  logic        tmp_prev_reg;
  logic        tmp_flag_reg;
  logic        io_drop;
  logic        chip_cause;
  logic        dbg_req;
  logic        wdt_tick;
  logic        wdt_expire;
  logic        tmp_evt;
  logic        chip_clr;
  logic        sys_clr;
  logic        apb_setup;
  logic        apb_wr;
  logic        kick;
  logic [31:0] rd_val;

  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      `SRS_OFF_CTRL, `SRS_OFF_STATUS, `SRS_OFF_WDT_CTRL, `SRS_OFF_WDT_LOAD,
      `SRS_OFF_WDT_KICK, `SRS_OFF_WDT_CNT, `SRS_OFF_CLK_CFG, `SRS_OFF_TMP_CTRL,
      `SRS_OFF_TMP_TIME, `SRS_OFF_TMP_DATE: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  function automatic logic wr_to(input logic [7:0] a, input logic [7:0] off, input logic we);
    wr_to = we && (a == off);
  endfunction

  // Reset causes
  assign io_drop    = i_io_trip_high_nv ? i_io_below_high_trip : i_io_below_low_trip;
  // Core dropout bypasses every control bit
  assign chip_cause = i_power_up | i_core_dropout
                    | (io_drop & ~ctrl_reg[`SRS_CTRL_MON_DIS] & ~ctrl_reg[`SRS_CTRL_IO_BLK]);
  assign dbg_req    = i_debug_mode & i_debug_reset_cmd;
  assign chip_clr   = (state_reg == SRS_POR_WAIT) || (state_reg == SRS_POR_HOLD);
  assign sys_clr    = (state_reg != SRS_RUN);

  // Reset pin: two-stage sync, then low-time filter
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_s1_reg <= 1'b1;
      pin_s2_reg <= 1'b1;
    end else begin
      pin_s1_reg <= i_board_reset_request_pin_n;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_lo_cnt_reg <= 16'h0000;
    end else if (pin_s2_reg) begin
      pin_lo_cnt_reg <= 16'h0000;
    end else if (pin_lo_cnt_reg != 16'(RIN_CYCLES)) begin
      pin_lo_cnt_reg <= pin_lo_cnt_reg + 16'h0001;
    end
  end
  // Fires once per low pulse that reaches the minimum width
  assign pin_req = !pin_s2_reg && (pin_lo_cnt_reg == 16'(RIN_CYCLES - 1));

  // Reset sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SRS_POR_WAIT: state_next = SRS_POR_HOLD;
      SRS_POR_HOLD: if (hold_cnt_reg == 16'(POR_CYCLES - 1)) state_next = SRS_RUN;
      SRS_RUN:      if (wdt_expire || pin_req || dbg_req) state_next = SRS_SYS_HOLD;
      SRS_SYS_HOLD: if (hold_cnt_reg == 16'(POR_CYCLES - 1)) state_next = SRS_RUN;
      default:      state_next = SRS_POR_WAIT;
    endcase
    if (chip_cause) state_next = SRS_POR_WAIT;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= SRS_POR_WAIT;
    end else begin
      state_reg <= state_next;
    end
  end

  // Pin held low keeps the system reset extended
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      hold_cnt_reg <= 16'h0000;
    end else if (state_next != state_reg || (state_reg == SRS_SYS_HOLD && !pin_s2_reg)) begin
      hold_cnt_reg <= 16'h0000;
    end else if (state_reg != SRS_RUN) begin
      hold_cnt_reg <= hold_cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_chip_wide_reset         <= 1'b1;
      o_system_level_reset      <= 1'b1;
      o_board_reset_drive_pin_n <= 1'b0;
      o_reset_phase             <= SRS_POR_WAIT;
    end else begin
      o_chip_wide_reset         <= (state_next == SRS_POR_WAIT) || (state_next == SRS_POR_HOLD);
      o_system_level_reset      <= (state_next != SRS_RUN);
      o_board_reset_drive_pin_n <= (state_next == SRS_RUN);
      o_reset_phase             <= state_next;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_fetch_addr <= `SRS_BOOT_VECTOR;
    end else if (chip_clr) begin
      o_fetch_addr <= `SRS_BOOT_VECTOR;
    end
  end

  // APB slave, zero wait states
  assign apb_setup = i_psel & ~i_penable;
  assign apb_wr    = i_psel & i_penable & o_pready & i_pwrite & ~sys_clr;
  assign kick      = wr_to(i_paddr, `SRS_OFF_WDT_KICK, apb_wr);

  always_comb begin
    rd_val = 32'h0000_0000;
    case (i_paddr)
      `SRS_OFF_CTRL:     rd_val = {28'h0000000, ctrl_reg};
      `SRS_OFF_STATUS:   rd_val = {27'h0000000, status_reg};
      `SRS_OFF_WDT_CTRL: rd_val = {16'h0000, wdt_presc_reg, 6'h00, wdt_mode_reg, wdt_en_reg};
      `SRS_OFF_WDT_LOAD: rd_val = {16'h0000, wdt_load_reg};
      `SRS_OFF_WDT_CNT:  rd_val = {16'h0000, wdt_cnt_reg};
      `SRS_OFF_CLK_CFG:  rd_val = o_clock_unit_cfg;
      `SRS_OFF_TMP_CTRL: rd_val = {23'h000000, tmp_flag_reg, 5'h00, tmp_ctrl_reg};
      `SRS_OFF_TMP_TIME: rd_val = o_tamper_time;
      `SRS_OFF_TMP_DATE: rd_val = o_tamper_date;
      default:           rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= apb_setup;
      o_prdata  <= (apb_setup && !i_pwrite) ? rd_val : 32'h0000_0000;
      o_pslverr <= apb_setup && !is_mapped(i_paddr);
    end
  end

  // Supply monitor control, lost on any reset
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_reg <= 4'h0;
    end else if (sys_clr) begin
      ctrl_reg <= 4'h0;
    end else if (wr_to(i_paddr, `SRS_OFF_CTRL, apb_wr)) begin
      ctrl_reg <= i_pwdata[3:0];
    end
  end

  // Clock unit settings survive a system reset
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_clock_unit_cfg <= `SRS_CLK_CFG_RST;
    end else if (chip_clr) begin
      o_clock_unit_cfg <= `SRS_CLK_CFG_RST;
    end else if (wr_to(i_paddr, `SRS_OFF_CLK_CFG, apb_wr)) begin
      o_clock_unit_cfg <= i_pwdata;
    end
  end

  // Cause status: read-only, cleared only by power-up; a new cause is never lost
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      status_reg <= `SRS_STATUS_RST;
    end else begin
      status_reg <= (i_power_up ? `SRS_STATUS_RST : status_reg)
                  | {dbg_req && state_reg == SRS_RUN,
                     pin_req && state_reg == SRS_RUN,
                     wdt_expire && state_reg == SRS_RUN,
                     chip_cause && !i_power_up,
                     1'b0};
    end
  end

  // Brown-out early warning, level while sag persists
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_brownout_irq <= 1'b0;
    end else begin
      o_brownout_irq <= !sys_clr && !ctrl_reg[`SRS_CTRL_MON_DIS]
                      && ((i_core_sag && !ctrl_reg[`SRS_CTRL_MSK_CORE])
                       || (i_io_sag && !ctrl_reg[`SRS_CTRL_MSK_IO]));
    end
  end

  // Watchdog / free-running timer on the bus clock
  assign wdt_tick   = wdt_en_reg && (presc_cnt_reg == 8'h00);
  assign wdt_expire = wdt_en_reg && wdt_mode_reg && (wdt_cnt_reg == 16'h0000);

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wdt_en_reg    <= 1'b0;
      wdt_mode_reg  <= 1'b0;
      wdt_presc_reg <= 8'h00;
      wdt_load_reg  <= `SRS_WDT_LOAD_RST;
    end else if (sys_clr) begin
      wdt_en_reg    <= 1'b0;
      wdt_mode_reg  <= 1'b0;
      wdt_presc_reg <= 8'h00;
      wdt_load_reg  <= `SRS_WDT_LOAD_RST;
    end else begin
      if (wr_to(i_paddr, `SRS_OFF_WDT_CTRL, apb_wr)) begin
        wdt_en_reg    <= i_pwdata[`SRS_WDT_EN];
        wdt_mode_reg  <= i_pwdata[`SRS_WDT_WD_MODE];
        wdt_presc_reg <= i_pwdata[15:8];
      end
      if (wr_to(i_paddr, `SRS_OFF_WDT_LOAD, apb_wr)) begin
        wdt_load_reg <= i_pwdata[15:0];
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      presc_cnt_reg <= 8'h00;
    end else if (sys_clr || kick || wdt_tick) begin
      presc_cnt_reg <= sys_clr ? 8'h00 : wdt_presc_reg;
    end else if (wdt_en_reg) begin
      presc_cnt_reg <= presc_cnt_reg - 8'h01;
    end
  end

  // Watchdog mode parks at zero until the system reset clears it
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wdt_cnt_reg <= `SRS_WDT_LOAD_RST;
    end else if (sys_clr) begin
      wdt_cnt_reg <= `SRS_WDT_LOAD_RST;
    end else if (kick) begin
      wdt_cnt_reg <= wdt_load_reg;
    end else if (wdt_tick) begin
      if (wdt_cnt_reg != 16'h0000) begin
        wdt_cnt_reg <= wdt_cnt_reg - 16'h0001;
      end else if (!wdt_mode_reg) begin
        wdt_cnt_reg <= wdt_load_reg;
      end
    end
  end

  // Tamper front end; contact mode fires while open and not yet flagged
  assign tmp_evt = tmp_ctrl_reg[`SRS_TMP_EN] && (tmp_ctrl_reg[`SRS_TMP_EDGE]
                 ? (tmp_ctrl_reg[`SRS_TMP_RISE] ? (i_tamper_in && !tmp_prev_reg)
                                                : (!i_tamper_in && tmp_prev_reg))
                 : (i_tamper_in && !tmp_flag_reg));

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      tmp_prev_reg <= 1'b0;
      tmp_ctrl_reg <= 3'h0;
    end else begin
      tmp_prev_reg <= i_tamper_in;
      if (sys_clr) begin
        tmp_ctrl_reg <= 3'h0;
      end else if (wr_to(i_paddr, `SRS_OFF_TMP_CTRL, apb_wr)) begin
        tmp_ctrl_reg <= i_pwdata[2:0];
      end
    end
  end

  // Flag clears on write-one; a new event in that cycle wins
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      tmp_flag_reg       <= 1'b0;
      o_sram_standby_cut <= 1'b0;
      o_tamper_capture   <= 1'b0;
      o_tamper_time      <= 32'h0000_0000;
      o_tamper_date      <= 32'h0000_0000;
    end else begin
      o_tamper_capture <= tmp_evt;
      if (tmp_evt) begin
        tmp_flag_reg       <= 1'b1;
        o_sram_standby_cut <= 1'b1;
        o_tamper_time      <= i_rtc_time;
        o_tamper_date      <= i_rtc_date;
      end else if (sys_clr || (wr_to(i_paddr, `SRS_OFF_TMP_CTRL, apb_wr)
                               && i_pwdata[`SRS_TMP_FLAG])) begin
        tmp_flag_reg       <= 1'b0;
        o_sram_standby_cut <= 1'b0;
      end
    end
  end

  // Checks
  chk_core_drop_reset: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_core_dropout |=> o_chip_wide_reset && !o_board_reset_drive_pin_n)
    else $error("core dropout did not force chip-wide reset");

  chk_power_up_reset: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_power_up |=> o_chip_wide_reset && o_system_level_reset)
    else $error("power-up condition did not reset the chip");

  chk_por_hold_len: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (state_reg == SRS_RUN) && ($past(state_reg) == SRS_POR_HOLD)
    |-> $past(hold_cnt_reg) == 16'(POR_CYCLES - 1))
    else $error("power-on hold ended at the wrong count");

  chk_pin_reset: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (state_reg == SRS_RUN) && pin_req && !chip_cause |=> o_system_level_reset
    && !o_chip_wide_reset && status_reg[`SRS_ST_PIN])
    else $error("valid reset pin pulse gave no system reset");

  chk_pin_glitch: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    pin_s2_reg ##1 !pin_s2_reg ##1 pin_s2_reg |-> !pin_req && $past(!pin_req))
    else $error("one-cycle pin glitch started a reset");

  chk_wdt_expire: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (state_reg == SRS_RUN) && wdt_expire && !chip_cause
    |=> (state_reg == SRS_SYS_HOLD) && status_reg[`SRS_ST_WATCHDOG] ##1 !wdt_en_reg)
    else $error("watchdog terminal count gave no system reset");

  chk_wdt_off_reset: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    sys_clr |=> !wdt_en_reg)
    else $error("watchdog enabled during or after a reset");

  chk_status_keep: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !i_power_up |=> (status_reg & $past(status_reg)) == $past(status_reg))
    else $error("cause status lost without power-up");

  chk_clk_cfg_keep: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (state_reg == SRS_SYS_HOLD) && !chip_cause |=> $stable(o_clock_unit_cfg))
    else $error("system reset altered clock unit settings");

  chk_chip_clr_cfg: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    chip_clr |=> o_clock_unit_cfg == `SRS_CLK_CFG_RST && !wdt_en_reg)
    else $error("chip-wide reset left clock unit settings");

  chk_irq_masked: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    ctrl_reg[`SRS_CTRL_MSK_CORE] && ctrl_reg[`SRS_CTRL_MSK_IO] |=> !o_brownout_irq)
    else $error("masked brown-out still raised interrupt");

  chk_tamper_cut: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    tmp_evt |=> o_sram_standby_cut && o_tamper_capture)
    else $error("tamper event did not cut standby supply");

  chk_tamper_time: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    tmp_evt |=> o_tamper_time == $past(i_rtc_time) && o_tamper_date == $past(i_rtc_date))
    else $error("tamper record does not hold event time");

  chk_debug_reset: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (state_reg == SRS_RUN) && dbg_req && !chip_cause |=> o_system_level_reset)
    else $error("debug reset command ignored");

  cov_wdt_expire: cover property (@(posedge i_ref_clk) disable iff (i_rst)
    (state_reg == SRS_RUN) && wdt_expire);
  cov_pin_reset: cover property (@(posedge i_ref_clk) disable iff (i_rst)
    (state_reg == SRS_RUN) && pin_req);
  cov_tamper: cover property (@(posedge i_ref_clk) disable iff (i_rst) tmp_evt);
endmodule
`default_nettype wire

/* srs_top_test.sv */
// Self-checking bench for the reset supervisor over APB.
// Assumes short POR and pin-filter counts to keep the run brief.
`include "srs_params.svh"
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch %s exp %0h got %0h", n, e, g); end end
module srs_top_test import srs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int POR = 8;
  localparam int RIN = 3;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, q, rdata, tt, td, fetch, ccfg;
  logic        tamper = 1'b0, e, ready, slverr, chip, sys, bpin_n, irq, tcap, cut;
  logic [31:0] rtime = 32'h1234_5678, rdate = 32'h0001_0203;
  srs_state_e  phase;
  wire logic   pu, cd, iol, ioh, nv, cs, ios, pin_n, dm, dc;
  int          num_errors = 0, checks_done = 0, waited;
  always #20 clk = ~clk;
  srs_partner srs_partner_i (.i_ref_clk(clk), .o_power_up(pu), .o_core_drop(cd),
    .o_io_low(iol), .o_io_high(ioh), .o_io_nv(nv), .o_core_sag(cs), .o_io_sag(ios),
    .o_pin_n(pin_n), .o_dbg_mode(dm), .o_dbg_cmd(dc));
  srs_top #(.POR_CYCLES(POR), .RIN_CYCLES(RIN)) srs_top_i (.i_ref_clk(clk), .i_rst(rst),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdata),
    .o_pready(ready), .o_prdata(rdata), .o_pslverr(slverr), .i_power_up(pu),
    .i_core_dropout(cd), .i_io_below_low_trip(iol), .i_io_below_high_trip(ioh),
    .i_io_trip_high_nv(nv), .i_core_sag(cs), .i_io_sag(ios),
    .i_board_reset_request_pin_n(pin_n), .i_debug_mode(dm), .i_debug_reset_cmd(dc),
    .i_tamper_in(tamper), .i_rtc_time(rtime), .i_rtc_date(rdate),
    .o_chip_wide_reset(chip), .o_system_level_reset(sys),
    .o_board_reset_drive_pin_n(bpin_n), .o_reset_phase(phase), .o_fetch_addr(fetch),
    .o_clock_unit_cfg(ccfg), .o_brownout_irq(irq), .o_tamper_capture(tcap),
    .o_tamper_time(tt), .o_tamper_date(td), .o_sram_standby_cut(cut));
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Request held until pready is seen high at a rising edge
  // No wait limit here: a missing pready is caught by the watchdog
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, pwr, addr, wdata} <= {1'b1, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    do begin @(posedge clk); end while (ready !== 1'b1);
    q = rdata;
    e = slverr;
    {psel, pen} <= 2'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wait_sys(input logic lvl, input int lim);
    waited = 0;
    while (sys !== lvl && waited < lim) begin @(posedge clk); waited++; end
    `CHK("system reset", lvl, sys)
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask
  initial begin
    settle(6);
    rst <= 1'b0;
    settle(20);
    `CHK("held while powering up", 1'b0, bpin_n)
    srs_partner_i.supply(7'h00);
    wait_sys(1'b0, 100);
    `CHK("por length", 1'b1, waited >= POR)
    `CHK("pin released", 1'b1, bpin_n)
    `CHK("phase run", SRS_RUN, phase)
    `CHK("boot vector", 32'h0, fetch)
    rd(`SRS_OFF_STATUS);
    `CHK("status power up", 32'h1, q)
    rd(`SRS_OFF_WDT_CTRL);
    `CHK("watchdog off", 32'h0, q)
    rd(8'hFC);
    `CHK("unmapped", 1'b1, e)
    wr(`SRS_OFF_CLK_CFG, 32'h0000_00A5);
    srs_partner_i.pin_low(RIN - 1);
    settle(10);
    `CHK("glitch ignored", 1'b0, sys)
    srs_partner_i.pin_low(RIN + 2);
    wait_sys(1'b1, 40);
    wait_sys(1'b0, 100);
    rd(`SRS_OFF_CLK_CFG);
    `CHK("clock kept", 32'hA5, q)
    srs_partner_i.dbg_reset();
    wait_sys(1'b1, 10);
    wait_sys(1'b0, 100);
    rd(`SRS_OFF_STATUS);
    `CHK("status pin debug", 32'h19, q)
    wr(`SRS_OFF_WDT_CTRL, 32'h1);
    rd(`SRS_OFF_WDT_CNT);
    `CHK("free running", 1'b1, q < 32'hFFFF)
    wr(`SRS_OFF_WDT_LOAD, 32'h10);
    wr(`SRS_OFF_WDT_CTRL, 32'h3);
    repeat (12) wr(`SRS_OFF_WDT_KICK, 32'h0);
    `CHK("kicks hold off", 1'b0, sys)
    wait_sys(1'b1, 60);
    wait_sys(1'b0, 100);
    rd(`SRS_OFF_WDT_CTRL);
    `CHK("watchdog off again", 32'h0, q)
    rd(`SRS_OFF_STATUS);
    `CHK("status watchdog", 32'h1D, q)
    srs_partner_i.supply(7'h02);
    settle(3);
    `CHK("early warning", 1'b1, irq)
    `CHK("no reset on sag", 1'b0, sys)
    srs_partner_i.supply(7'h01);
    settle(3);
    `CHK("io early warning", 1'b1, irq)
    wr(`SRS_OFF_CTRL, 32'hC);
    srs_partner_i.supply(7'h03);
    settle(3);
    `CHK("warning masked", 1'b0, irq)
    wr(`SRS_OFF_TMP_CTRL, 32'h7);
    tamper <= 1'b1;
    settle(3);
    `CHK("tamper time", 32'h1234_5678, tt)
    `CHK("tamper date", 32'h0001_0203, td)
    `CHK("memory cut", 1'b1, cut)
    rtime <= 32'h2345_6789;
    rdate <= 32'h0001_0204;
    wr(`SRS_OFF_TMP_CTRL, 32'h107);
    settle(2);
    `CHK("cut cleared", 1'b0, cut)
    `CHK("record held", 32'h1234_5678, tt)
    wr(`SRS_OFF_TMP_CTRL, 32'h103);
    tamper <= 1'b0;
    settle(2);
    `CHK("falling capture", 1'b1, tcap)
    `CHK("falling time", 32'h2345_6789, tt)
    `CHK("falling date", 32'h0001_0204, td)
    wr(`SRS_OFF_TMP_CTRL, 32'h101);
    tamper <= 1'b1;
    settle(2);
    `CHK("contact capture", 1'b1, tcap)
    `CHK("contact open", 1'b1, cut)
    wr(`SRS_OFF_CTRL, 32'h0);
    srs_partner_i.supply(7'h08);
    settle(8);
    `CHK("low trip kept", 1'b0, sys)
    srs_partner_i.supply(7'h18);
    wait_sys(1'b1, 10);
    `CHK("low trip reset", 1'b1, chip)
    srs_partner_i.supply(7'h00);
    wait_sys(1'b0, 100);
    wr(`SRS_OFF_CTRL, 32'h2);
    srs_partner_i.supply(7'h0C);
    settle(8);
    `CHK("io reset blocked", 1'b0, sys)
    wr(`SRS_OFF_CTRL, 32'h0);
    wait_sys(1'b1, 10);
    `CHK("chip wide", 1'b1, chip)
    srs_partner_i.supply(7'h00);
    wait_sys(1'b0, 100);
    rd(`SRS_OFF_CLK_CFG);
    `CHK("clock cleared", 32'h0, q)
    rd(`SRS_OFF_STATUS);
    `CHK("supply cause", 1'b1, q[1])
    wr(`SRS_OFF_CTRL, 32'h1);
    srs_partner_i.supply(7'h20);
    wait_sys(1'b1, 10);
    `CHK("core drop chip wide", 1'b1, chip)
    srs_partner_i.supply(7'h00);
    wait_sys(1'b0, 100);
    tally_and_finish();
  end
  // Whole sequence needs well under a thousand cycles
  initial begin
    settle(5000);
    num_errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
